// *** src/adcr_pkg.sv ***
// Purpose: constants and field layouts for the audio processing config block
// Assumes: registers sit on a 32-bit APB bus, one aligned word each
// Notes:   register byte address is four times the register index
package adcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] CFG_A_INDEX = 8'h03;   // processing_config_a
  localparam logic [7:0] CFG_B_INDEX = 8'h04;   // processing_config_b
  localparam logic [7:0] CFG_A_RESET = 8'h40;   // only zero detect set
  localparam logic [7:0] CFG_B_RESET = 8'hC2;
  localparam logic [7:0] CFG_B_WMASK = 8'hDB;   // bits 5 and 2 reserved

  // first configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic sub_mix_into_mains_en;
    logic zero_detect_mute_en;
    logic limiter_compress_mode;
    logic biquad_link;
    logic postscale_link;
    logic processing_bypass;
    logic emphasis_undo_en;
    logic dc_block_bypass;
  } adcr_cfg_a_t;

  // second configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic soft_volume_en;
    logic zero_cross_volume_en;
    logic rsvd5;
    logic pwm_rate_select;
    logic am_band_noise_reduce_en;
    logic rsvd2;
    logic max_power_correction_en;
    logic power_correction_variable;
  } adcr_cfg_b_t;

  ////////////////////////////////////////////////////////////////////////////
  // processing constants
  localparam int unsigned CHAN_N       = 3;
  localparam int unsigned SUB_CHAN     = 2;     // third channel is the sub
  localparam int unsigned ZD_SAMPLES   = 2048;
  localparam int unsigned ZD_CNT_W     = 12;
  localparam int unsigned HP_SHIFT     = 10;    // dc block pole
  localparam int unsigned EMPHASIS_UNDO_EN_SHIFT   = 2;     // de-emphasis pole
  localparam int unsigned MIX_SHIFT    = 1;     // sub mixed in at half level
  localparam int unsigned GAIN_SHIFT   = 7;     // gain 0x80 is unity
  localparam int unsigned PS_SHIFT     = 8;     // postscale 0xFF near unity
  localparam logic [15:0] MPC_STD_COEF = 16'h4000;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned PWM_NORM_HZ  = 384_000;
  localparam int unsigned PWM_ODD_HZ10 = 3_413_000;  // 341.3 kHz times ten
  localparam int unsigned PWM_NORM_CYC = CLK_HZ / PWM_NORM_HZ;
  localparam int unsigned PWM_ODD_CYC  = (CLK_HZ * 10) / PWM_ODD_HZ10;
  localparam int unsigned PWM_CNT_W    = 7;

endpackage

// *** src/adcr_top.sv ***
// Purpose: config registers a/b and the audio controls they drive
// Assumes: i_sample holds channels after input mapping, one set per i_valid
// Notes:   APB slave, zero wait states, prdata from a flop
//          prdata is captured in setup so it stands through access
//          unmapped offsets answer with pslverr and read as zero
//          one sample set per i_valid, all channels move together
//          gain starts at zero after reset and ramps to i_volume
//          pwm tick runs free, it is a rate marker for the modulator
`timescale 1ns/100ps
module adcr_top
#(
  parameter int unsigned SAMPLE_W = 24
)
(
  input  wire logic                                       i_ref_clk,
  input  wire logic                                       i_rst_n,
  input  wire logic                                       i_psel,
  input  wire logic                                       i_penable,
  input  wire logic                                       i_pwrite,
  input  wire logic [7:0]                                 i_paddr,
  input  wire logic [31:0]                                i_pwdata,
  input  wire logic [3:0]                                 i_pstrb,
  output logic      [31:0]                                o_prdata,
  output logic                                            o_pready,
  output logic                                            o_pslverr,
  input  wire logic                                       i_valid,
  input  wire logic [adcr_pkg::CHAN_N-1:0][SAMPLE_W-1:0]  i_sample,
  input  wire logic [adcr_pkg::CHAN_N-1:0][7:0]           i_volume,
  input  wire logic                                       i_vol_bypass,
  input  wire logic [adcr_pkg::CHAN_N-1:0][7:0]           i_postscale,
  input  wire logic [7:0]                                 i_limit_thresh,
  input  wire logic [15:0]                                i_power_corr_coef,
  output logic                                            o_valid,
  output logic      [adcr_pkg::CHAN_N-1:0][SAMPLE_W-1:0]  o_sample,
  output logic      [adcr_pkg::CHAN_N-1:0]                o_zero_muted,
  output logic      [adcr_pkg::CHAN_N-1:0][7:0]           o_gain,
  output logic      [adcr_pkg::CHAN_N-1:0][1:0]           o_biquad_bank,
  output logic      [adcr_pkg::CHAN_N-1:0][7:0]           o_limit_thresh,
  output logic                                            o_limit_compress,
  output logic      [15:0]                                o_power_corr_coef,
  output logic                                            o_am_noise_reduce,
  output logic                                            o_pwm_rate_select,
  output logic                                            o_pwm_tick
);

  localparam int unsigned CH = adcr_pkg::CHAN_N;
  localparam int unsigned WW = SAMPLE_W + 20;   // headroom for math
  localparam logic [7:0] ADDR_A = {adcr_pkg::CFG_A_INDEX[5:0], 2'b00};
  localparam logic [7:0] ADDR_B = {adcr_pkg::CFG_B_INDEX[5:0], 2'b00};
  localparam logic [adcr_pkg::ZD_CNT_W-1:0] ZD_LAST =
    adcr_pkg::ZD_CNT_W'(adcr_pkg::ZD_SAMPLES - 1);
  localparam logic [adcr_pkg::PWM_CNT_W-1:0] PWM_NORM_LAST =
    adcr_pkg::PWM_CNT_W'(adcr_pkg::PWM_NORM_CYC - 1);
  localparam logic [adcr_pkg::PWM_CNT_W-1:0] PWM_ODD_LAST =
    adcr_pkg::PWM_CNT_W'(adcr_pkg::PWM_ODD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state of the whole block
  // cfg_a and cfg_b are the two software visible registers
  // prdata holds the word captured in the read setup phase
  // hp_x and hp_y are the dc block input and output history
  // de_y is the de-emphasis shelf history, updated on every sample
  // so that enabling it later starts from a settled value
  // out holds the processed sample set until the next valid
  // zcnt counts consecutive zero samples per channel
  // muted is the zero detect mute per channel
  // gain is the volume actually applied, stepped toward the target
  // prev_neg remembers the sign of the last sample for crossings
  // pwm_cnt and pwm_tick form the pwm rate divider
  typedef struct packed {
    adcr_pkg::adcr_cfg_a_t                 cfg_a;
    adcr_pkg::adcr_cfg_b_t                 cfg_b;
    logic [31:0]                           prdata;
    logic                                  valid;
    logic [CH-1:0][SAMPLE_W-1:0]           hp_x;
    logic [CH-1:0][SAMPLE_W-1:0]           hp_y;
    logic [CH-1:0][SAMPLE_W-1:0]           de_y;
    logic [CH-1:0][SAMPLE_W-1:0]           out;
    logic [CH-1:0][adcr_pkg::ZD_CNT_W-1:0] zcnt;
    logic [CH-1:0]                         muted;
    logic [CH-1:0][7:0]                    gain;
    logic [CH-1:0]                         prev_neg;
    logic [adcr_pkg::PWM_CNT_W-1:0]        pwm_cnt;
    logic                                  pwm_tick;
  } adcr_state_t;

  adcr_state_t                 st_q;
  adcr_state_t                 next_st;
  logic                        wr_acc;
  logic                        rd_setup;
  logic                        hit_a;
  logic                        hit_b;

  // clamp a wide result back to the sample width
  // saturating rather than wrapping keeps a loud overflow from
  // flipping sign, which would be a full scale click at the output
  // all intermediate math is done WW bits wide, signed
  function automatic logic [SAMPLE_W-1:0] clamp(input logic signed [WW-1:0] v);
    logic signed [WW-1:0] hi;
    logic signed [WW-1:0] lo;
    hi = WW'($signed({1'b0, {(SAMPLE_W-1){1'b1}}}));
    lo = WW'($signed({1'b1, {(SAMPLE_W-1){1'b0}}}));
    if (v > hi)
      clamp = hi[SAMPLE_W-1:0];
    else if (v < lo)
      clamp = lo[SAMPLE_W-1:0];
    else
      clamp = v[SAMPLE_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  // writes land at the access edge, only byte lane 0 carries data
  // reads are captured at the setup edge from the registered value
  // pready is tied high, every transfer ends after one access cycle
  // pslverr only flags offsets that hold no register
  assign hit_a    = (i_paddr == ADDR_A);
  assign hit_b    = (i_paddr == ADDR_B);
  assign wr_acc   = i_psel & i_penable & i_pwrite & i_pstrb[0];
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign o_pready  = 1'b1;                                 // no wait states
  assign o_pslverr = i_psel & i_penable & ~(hit_a | hit_b);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic signed [WW-1:0]        x;
    logic signed [WW-1:0]        t;
    logic signed [WW-1:0]        sub;
    logic [CH-1:0][SAMPLE_W-1:0] mid;
    logic [7:0]                  ps;
    logic                        zc;
    logic                        step_ok;
    x       = '0;
    t       = '0;
    sub     = '0;
    mid     = '0;
    ps      = '0;
    zc      = 1'b0;
    step_ok = 1'b0;
    next_st = st_q;

    // register writes, reserved bits kept zero
    if (wr_acc && hit_a)
      next_st.cfg_a = i_pwdata[7:0];
    if (wr_acc && hit_b)
      next_st.cfg_b = i_pwdata[7:0] & adcr_pkg::CFG_B_WMASK;

    // read data captured in setup, stable through access
    if (rd_setup)
    begin
      if (hit_a)
        next_st.prdata = {24'h000000, st_q.cfg_a};
      else if (hit_b)
        next_st.prdata = {24'h000000, st_q.cfg_b};
      else
        next_st.prdata = 32'h00000000;
    end

    // pwm rate tick generator
    // the compare is greater-or-equal so that switching to the faster
    // rate while the counter is past its new end wraps at once
    // instead of running round the whole counter range
    if (st_q.pwm_cnt >= (st_q.cfg_b.pwm_rate_select ?
                         PWM_ODD_LAST : PWM_NORM_LAST))
    begin
      next_st.pwm_cnt  = '0;
      next_st.pwm_tick = 1'b1;
    end
    else
    begin
      next_st.pwm_cnt  = st_q.pwm_cnt + 1'b1;
      next_st.pwm_tick = 1'b0;
    end

    // disabling zero detect releases its mute
    if (!st_q.cfg_a.zero_detect_mute_en)
    begin
      next_st.muted = '0;
      next_st.zcnt  = '0;
    end

    next_st.valid = i_valid;

    if (i_valid)
    begin
      // front end filters per channel
      for (int c = 0; c < CH; c++)
      begin
        x = WW'($signed(i_sample[c]));
        // dc block: y = x - x1 + y1 - y1/2^k
        t = x - WW'($signed(st_q.hp_x[c])) + WW'($signed(st_q.hp_y[c]))
            - (WW'($signed(st_q.hp_y[c])) >>> adcr_pkg::HP_SHIFT);
        next_st.hp_x[c] = i_sample[c];
        next_st.hp_y[c] = clamp(t);
        mid[c] = st_q.cfg_a.dc_block_bypass ? i_sample[c] : clamp(t);
        // de-emphasis one pole shelf
        t = WW'($signed(st_q.de_y[c]))
            + ((WW'($signed(mid[c])) - WW'($signed(st_q.de_y[c])))
               >>> adcr_pkg::EMPHASIS_UNDO_EN_SHIFT);
        next_st.de_y[c] = clamp(t);
        if (st_q.cfg_a.emphasis_undo_en &&
            !st_q.cfg_a.processing_bypass)
          mid[c] = clamp(t);

        // zero detect on mapped channel input
        // the count saturates at its last value while zeros go on,
        // so the mute stays set and the counter never wraps
        // the sample that completes the run is still passed on,
        // outputs are silenced from the next sample onward
        if (st_q.cfg_a.zero_detect_mute_en)
        begin
          if (i_sample[c] == '0)
          begin
            if (st_q.zcnt[c] == ZD_LAST)
              next_st.muted[c] = 1'b1;
            else
              next_st.zcnt[c] = st_q.zcnt[c] + 1'b1;
          end
          else
          begin
            next_st.zcnt[c]  = '0;
            next_st.muted[c] = 1'b0;
          end
        end

        // volume update, optionally only at a zero crossing
        // a crossing is a zero sample or a change of sign since the
        // previous sample of the same channel
        // soft stepping moves one gain step per sample, so a full
        // swing takes up to 255 samples
        zc = (i_sample[c] == '0) ||
             (i_sample[c][SAMPLE_W-1] != st_q.prev_neg[c]);
        next_st.prev_neg[c] = i_sample[c][SAMPLE_W-1];
        step_ok = zc || !st_q.cfg_b.zero_cross_volume_en;
        if (step_ok && st_q.gain[c] != i_volume[c])
        begin
          if (st_q.cfg_b.soft_volume_en && !i_vol_bypass)
            next_st.gain[c] = (st_q.gain[c] < i_volume[c]) ?
                              st_q.gain[c] + 8'h01 : st_q.gain[c] - 8'h01;
          else
            next_st.gain[c] = i_volume[c];
        end
      end

      // mixing, volume and postscale
      // the sub is mixed in at half level to leave headroom
      // processing bypass removes the mix but keeps volume
      // postscale is the very last stage before the modulator,
      // so it caps the modulation index whatever the volume
      sub = WW'($signed(mid[adcr_pkg::SUB_CHAN]));
      for (int c = 0; c < CH; c++)
      begin
        x = WW'($signed(mid[c]));
        if (st_q.cfg_a.sub_mix_into_mains_en &&
            !st_q.cfg_a.processing_bypass && c != adcr_pkg::SUB_CHAN)
          x = x + (sub >>> adcr_pkg::MIX_SHIFT);
        t  = (x * $signed({1'b0, st_q.gain[c]})) >>> adcr_pkg::GAIN_SHIFT;
        x  = WW'($signed(clamp(t)));
        ps = st_q.cfg_a.postscale_link ? i_postscale[0] : i_postscale[c];
        t  = (x * $signed({1'b0, ps})) >>> adcr_pkg::PS_SHIFT;
        next_st.out[c] = st_q.muted[c] ? '0 : clamp(t);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // reset loads only constants, the register reset values come
  // from the package so software sees the documented defaults
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q          <= '0;
      st_q.cfg_a    <= adcr_pkg::CFG_A_RESET;
      st_q.cfg_b    <= adcr_pkg::CFG_B_RESET;
    end
    else
      st_q <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs
  // bank select follows the biquad link bit directly, limiter thresholds depend on the limiter mode
  // compression scales the threshold by the applied gain, so it
  // tracks volume; anti-clip passes the setting through unchanged
  // the scaled threshold saturates at full scale
  always_comb
  begin
    for (int c = 0; c < CH; c++)
    begin
      logic [15:0] thr;
      thr = '0;
      // bank of channel 0 when linked
      o_biquad_bank[c] = st_q.cfg_a.biquad_link ? 2'h0 : 2'(c);
      thr = {8'h00, i_limit_thresh} * {8'h00, st_q.gain[c]};
      if (st_q.cfg_a.limiter_compress_mode)
        o_limit_thresh[c] = (thr[15:adcr_pkg::GAIN_SHIFT] > 9'h0FF) ?
                            8'hFF : thr[adcr_pkg::GAIN_SHIFT+7:
                                        adcr_pkg::GAIN_SHIFT];
      else
        o_limit_thresh[c] = i_limit_thresh;
    end
  end

  // power correction coefficient select
  // a zero coefficient means no correction is applied
  // the variable source is the external coefficient registers
  always_comb
  begin
    if (!st_q.cfg_b.max_power_correction_en)
      o_power_corr_coef = 16'h0000;
    else if (st_q.cfg_b.power_correction_variable)
      o_power_corr_coef = i_power_corr_coef;
    else
      o_power_corr_coef = adcr_pkg::MPC_STD_COEF;
  end

  // data and mode outputs straight from flops
  // none of these depend on the bus inputs combinationally
  assign o_prdata          = st_q.prdata;
  assign o_valid           = st_q.valid;
  assign o_sample          = st_q.out;
  assign o_zero_muted      = st_q.muted;
  assign o_gain            = st_q.gain;
  assign o_limit_compress  = st_q.cfg_a.limiter_compress_mode;
  assign o_am_noise_reduce = st_q.cfg_b.am_band_noise_reduce_en;
  assign o_pwm_rate_select = st_q.cfg_b.pwm_rate_select;
  assign o_pwm_tick        = st_q.pwm_tick;

endmodule

// *** test/adcr_top_sva.sv ***
// Purpose: assertions on the ports of the audio config block
// Assumes: register a at byte 0x0C, register b at byte 0x10
// Notes:   shadow copies of both registers follow apb writes
`timescale 1ns/100ps
module adcr_top_sva
#(
  parameter int unsigned SAMPLE_W = 24
)
(
  input wire logic                     i_ref_clk,
  input wire logic                     i_rst_n,
  input wire logic                     i_psel,
  input wire logic                     i_penable,
  input wire logic                     i_pwrite,
  input wire logic [7:0]               i_paddr,
  input wire logic [31:0]              i_pwdata,
  input wire logic                     i_valid,
  input wire logic [2:0][SAMPLE_W-1:0] i_sample,
  input wire logic [7:0]               i_limit_thresh,
  input wire logic [15:0]              i_power_corr_coef,
  input wire logic [2:0]               o_zero_muted,
  input wire logic [2:0][1:0]          o_biquad_bank,
  input wire logic [2:0][7:0]          o_limit_thresh,
  input wire logic                     o_limit_compress,
  input wire logic [15:0]              o_power_corr_coef,
  input wire logic                     o_am_noise_reduce,
  input wire logic                     o_pwm_rate_select,
  input wire logic                     o_pwm_tick,
  input wire logic                     o_valid
);
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [6:0] gap;
  logic       clean;
  logic       wr;

  ////////////////////////////////////////////////////////////////////////////
  // shadow registers, cycles since last pwm tick, clean period flag
  assign wr = i_psel & i_penable & i_pwrite;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_a  <= 8'h40;
      sh_b  <= 8'hC2;
      gap   <= 7'h00;
      clean <= 1'h0;
    end
    else
    begin
      sh_a  <= (wr && i_paddr == 8'h0C) ? i_pwdata[7:0] : sh_a;
      sh_b  <= (wr && i_paddr == 8'h10) ? i_pwdata[7:0] & 8'hDB : sh_b;
      gap   <= o_pwm_tick ? 7'h00 : gap + 7'h01;
      clean <= (o_pwm_tick | clean) & ~(wr && i_paddr == 8'h10);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs against the register fields
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  mode_sel_a: assert property (o_limit_compress == sh_a[5])
    else $error("limiter mode output wrong");
  am_mode_a: assert property (o_am_noise_reduce == sh_b[3])
    else $error("am mode output wrong");
  pwm_sel_a: assert property (o_pwm_rate_select == sh_b[4])
    else $error("pwm rate output wrong");
  bank_link_a: assert property (
    o_biquad_bank == (sh_a[4] ? 6'h00 : 6'h24))
    else $error("coefficient bank select wrong");
  tick_gap_a: assert property (
    o_pwm_tick && clean |-> gap == (sh_b[4] ? 7'h39 : 7'h33))
    else $error("pwm tick spacing wrong");
  corr_coef_a: assert property (
    o_power_corr_coef == (!sh_b[1] ? 16'h0000 :
      (sh_b[0] ? i_power_corr_coef : adcr_pkg::MPC_STD_COEF)))
    else $error("power correction coefficient wrong");
  anti_clip_a: assert property (
    !o_limit_compress |-> o_limit_thresh == {3{i_limit_thresh}})
    else $error("anti-clip threshold not constant");
  zero_unmute_a: assert property (
    i_valid && i_sample[0] != '0 |=> !o_zero_muted[0])
    else $error("mute kept after non-zero sample");
  valid_echo_a: assert property (o_valid == $past(i_valid))
    else $error("output valid not one cycle after input valid");
endmodule

bind adcr_top adcr_top_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_valid(i_valid), .i_sample(i_sample),
  .i_limit_thresh(i_limit_thresh), .o_zero_muted(o_zero_muted),
  .i_power_corr_coef(i_power_corr_coef), .o_biquad_bank(o_biquad_bank),
  .o_limit_thresh(o_limit_thresh), .o_limit_compress(o_limit_compress),
  .o_power_corr_coef(o_power_corr_coef), .o_pwm_tick(o_pwm_tick),
  .o_am_noise_reduce(o_am_noise_reduce),
  .o_pwm_rate_select(o_pwm_rate_select), .o_valid(o_valid));

// *** test/audio_dsp_config_regs_tb.sv ***
// Purpose: self-checking bench for the audio config block
// Assumes: samples checked at unity gain with exact power-of-two scaling
// Notes:   apb master waits on pready, watchdog cuts a hang
`timescale 1ns/100ps
module audio_dsp_config_regs_tb;
  logic             i_ref_clk, i_rst_n, i_psel, i_penable, i_pwrite;
  logic             o_pready, o_pslverr, i_valid, i_vol_bypass, err;
  logic [7:0]       i_paddr;
  logic [31:0]      i_pwdata, o_prdata, rd;
  logic [2:0][23:0] i_sample, o_sample;
  logic [2:0][7:0]  i_volume, i_postscale, o_gain, o_limit_thresh;
  logic [2:0]       o_zero_muted;
  int               n_errors, comparisons;

  adcr_top dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(4'hF), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_valid(i_valid),
    .i_sample(i_sample), .i_volume(i_volume), .i_postscale(i_postscale),
    .i_vol_bypass(i_vol_bypass), .i_limit_thresh(8'h40),
    .i_power_corr_coef(16'h1234), .o_valid(), .o_sample(o_sample),
    .o_zero_muted(o_zero_muted), .o_gain(o_gain), .o_biquad_bank(),
    .o_limit_thresh(o_limit_thresh), .o_limit_compress(),
    .o_power_corr_coef(), .o_am_noise_reduce(), .o_pwm_rate_select(),
    .o_pwm_tick());

  ////////////////////////////////////////////////////////////////////////////
  // clock, compare, verdict
  initial
  begin
    i_ref_clk = 1'h0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel    <= 1'h1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'h1)
      @(posedge i_ref_clk);
    rd        = o_prdata;
    err       = o_pslverr;
    i_psel    <= 1'h0;
    i_penable <= 1'h0;
  endtask

  // n sample sets, then let the outputs settle
  task automatic push(input logic [2:0][23:0] s, input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      i_valid  <= 1'h1;
      i_sample <= s;
      @(posedge i_ref_clk);
      i_valid  <= 1'h0;
    end
    repeat (2) @(posedge i_ref_clk);
  endtask

  // main sequence
  initial
  begin
    {n_errors, comparisons} = 0;
    {i_rst_n, i_psel, i_penable, i_pwrite, i_valid, i_vol_bypass} = 6'h00;
    {i_paddr, i_pwdata, i_sample} = '0;
    i_volume    = {3{8'h10}};
    i_postscale = {8'h20, 8'h40, 8'h80};
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    apb(1'h0, 8'h0C, 32'h0);
    check(rd, 32'h40);
    apb(1'h0, 8'h10, 32'h0);
    check(rd, 32'hC2);
    apb(1'h1, 8'h0C, 32'hFF);
    apb(1'h0, 8'h0C, 32'h0);
    check(rd, 32'hFF);
    apb(1'h1, 8'h10, 32'hFF);
    apb(1'h0, 8'h10, 32'h0);
    check(rd, 32'hDB);
    apb(1'h1, 8'h14, 32'hFF);
    check(err, 1'h1);
    apb(1'h0, 8'h14, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, 8'h10, 32'h80);
    push({3{24'h000100}}, 5);
    check(o_gain, {3{8'h05}});
    apb(1'h1, 8'h10, 32'h00);
    push({3{24'h000100}}, 1);
    check(o_gain, {3{8'h10}});
    apb(1'h1, 8'h10, 32'h40);
    i_volume <= {3{8'h20}};
    push({3{24'h000100}}, 1);
    check(o_gain, {3{8'h10}});
    push({3{24'h000000}}, 1);
    check(o_gain, {3{8'h20}});
    apb(1'h1, 8'h10, 32'h80);
    i_vol_bypass <= 1'h1;
    i_volume     <= {3{8'h30}};
    push({3{24'h000100}}, 1);
    check(o_gain, {3{8'h30}});
    apb(1'h1, 8'h0C, 32'h20);
    @(posedge i_ref_clk);
    check(o_limit_thresh, {3{8'h18}});
    i_vol_bypass <= 1'h0;
    i_volume     <= {3{8'h80}};
    apb(1'h1, 8'h10, 32'h00);
    apb(1'h1, 8'h0C, 32'h0D);
    push({3{24'h010000}}, 2);
    check(o_sample, {3{24'h008000}});
    apb(1'h1, 8'h0C, 32'h05);
    push({3{24'h010000}}, 2);
    check(o_sample, {24'h002000, 24'h004000, 24'h008000});
    i_postscale <= {3{8'h80}};
    apb(1'h1, 8'h0C, 32'h81);
    push({24'h020000, 24'h010000, 24'h010000}, 2);
    check(o_sample, {3{24'h010000}});
    apb(1'h1, 8'h0C, 32'h87);
    push({24'h020000, 24'h010000, 24'h010000}, 2);
    check(o_sample, {24'h010000, {2{24'h008000}}});
    apb(1'h1, 8'h0C, 32'h41);
    push({3{24'h000100}}, 1);
    push({24'h000100, 24'h000100, 24'h0}, 2047);
    check(o_zero_muted, 3'h0);
    push({24'h000100, 24'h000100, 24'h0}, 1);
    check(o_zero_muted, 3'h1);
    push({3{24'h000100}}, 1);
    check(o_zero_muted, 3'h0);
    push({24'h000100, 24'h000100, 24'h0}, 2048);
    check(o_zero_muted, 3'h1);
    apb(1'h1, 8'h0C, 32'h01);
    repeat (3) @(posedge i_ref_clk);
    check(o_zero_muted, 3'h0);
    apb(1'h1, 8'h10, 32'h10);
    apb(1'h1, 8'h0C, 32'h03);
    push({24'h000000, 24'h000000, 24'h010000}, 1);
    check(o_sample[0], 24'h002000);
    repeat (150) @(posedge i_ref_clk);
    wrap_up();
  end

  // watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge i_ref_clk);
    n_errors++;
    wrap_up();
  end
endmodule
